// File: power_measurement_datapath.sv
`timescale 1ns/10ps
// measurement datapath: decimation, correction, power, energy, rms, bus
// Function
// - modulator bit taken every eight divided clocks
// - one 24-bit word per 1024 divided clocks
// - voltage sinc2 decimator, current sinc4 decimator
// - voltage delayed by seven-bit phase code
// - fir droop correction on both channels
// - optional dc block ahead of rms, energy
// - allpass on other channel when one blocked
// - add offset, multiply gain, store instant sample
// - power is voltage times current per conversion
// - each power sample stored to power register
// - energy summed over groups of n conversions
// - energy sum shifted right twelve before storing
// - rms of last n voltage, current samples
// - current has two ranges, voltage one
// - pulses proportional to accumulated real energy
// - all filters paced by divided clock
// - conversion flag set each conversion, maskable irq
// - cycle flag set per n conversions, maskable irq
// - signed results saturate as twos complement fractions
module power_measurement_datapath #(
  parameter int DIV_K   = 1,        // master clock divider
  parameter int PULSE_Q = 1 << 20   // energy quantum per pulse
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        v_mod_bit,
  input  wire logic        i_mod_bit,
  output logic             irq,
  output logic             pulse_pos,
  output logic             pulse_neg
);
  if (DIV_K < 1 || DIV_K > 255 || PULSE_Q < 1) begin : g_chk
    $error("unsupported parameter value");
  end

  // ==========================================================
  // helpers
  // clamp to a signed 24-bit fraction
  function automatic logic [23:0] sat24(input logic signed [63:0] x);
    if (x > 64'sd8388607) return 24'h7F_FFFF;
    if (x < -64'sd8388608) return 24'h80_0000;
    return x[23:0];
  endfunction : sat24
  // three-tap droop lift centred on b
  function automatic logic signed [31:0] fir3(
    input logic signed [31:0] a, b, c);
    return b + ((2 * b - a - c) >>> pmd_pkg::FIR_SH);
  endfunction : fir3
  // one bit of a quotient or root by trial product
  function automatic logic [23:0] try_bit(input logic [23:0] cur,
    input logic [4:0] b, input logic [23:0] m,
    input logic [47:0] tgt, input logic sq);
    logic [23:0] t;
    logic [47:0] p;
    t = cur | (24'h00_0001 << b);
    p = t * (sq ? t : m);
    return (p <= tgt) ? t : cur;
  endfunction : try_bit

  // ==========================================================
  // register file state
  logic [10:0]      cfg_r, cfg_nxt;
  pmd_pkg::cfg_t    cfg;
  logic [23:0]      voff_r, voff_nxt, ioff_r, ioff_nxt;
  logic [23:0]      vgn_r, vgn_nxt, ign_r, ign_nxt;
  logic [23:0]      ncyc_r, ncyc_nxt;
  logic [1:0]       stat_r, stat_nxt, mask_r, mask_nxt;
  logic             ack_nxt;
  logic [31:0]      dat_nxt;
  assign cfg = pmd_pkg::cfg_t'(cfg_r);

  // ==========================================================
  // divided clock pacing and front end
  logic [7:0]  kcnt_r, kcnt_nxt;
  logic [2:0]  sub8_r, sub8_nxt;
  logic [6:0]  dec_r, dec_nxt;
  logic [1:0]  vsy_r, vsy_nxt, isy_r, isy_nxt;  // pin synchronisers
  logic [127:0] vsh_r, vsh_nxt;                // phase delay line
  logic signed [15:0] vin_r [2], vin_nxt [2];  // sinc2 integrators
  logic signed [15:0] vcp_r [2], vcp_nxt [2];  // sinc2 comb memory
  logic signed [29:0] iin_r [4], iin_nxt [4];  // sinc4 integrators
  logic signed [29:0] icp_r [4], icp_nxt [4];  // sinc4 comb memory
  logic signed [31:0] hv_r [3], hv_nxt [3];    // voltage word history
  logic signed [31:0] hi_r [3], hi_nxt [3];    // current word history
  logic        s1_r;                           // word ready to process
  logic        dtick, mod_tick, word_tick, vbit;
  logic signed [15:0] vc;
  logic signed [29:0] ic;
  assign dtick = kcnt_r == 8'(DIV_K - 1);
  assign mod_tick = dtick && sub8_r == 3'(pmd_pkg::MOD_DCLK - 1);
  assign word_tick = mod_tick &&
                     dec_r == 7'(pmd_pkg::WORD_MOD - 1);
  assign vbit = vsh_r[cfg.phase];

  // integrate on each modulator bit, comb on each word
  always_comb begin
    kcnt_nxt = dtick ? 8'h00 : kcnt_r + 8'h01;
    sub8_nxt = dtick ? sub8_r + 3'h1 : sub8_r;
    dec_nxt = mod_tick ? dec_r + 7'h01 : dec_r;
    vsy_nxt = {vsy_r[0], v_mod_bit};
    isy_nxt = {isy_r[0], i_mod_bit};
    vsh_nxt = mod_tick ? {vsh_r[126:0], vsy_r[1]} : vsh_r;
    vin_nxt = vin_r;
    iin_nxt = iin_r;
    vcp_nxt = vcp_r;
    icp_nxt = icp_r;
    hv_nxt = hv_r;
    hi_nxt = hi_r;
    vc = vin_r[1];
    ic = iin_r[3];
    if (mod_tick) begin
      vin_nxt[0] = vin_r[0] + (vbit ? 16'sd1 : -16'sd1);
      vin_nxt[1] = vin_r[1] + vin_r[0];
      iin_nxt[0] = iin_r[0] + (isy_r[1] ? 30'sd1 : -30'sd1);
      for (int k = 1; k < 4; k++) iin_nxt[k] = iin_r[k] + iin_r[k-1];
    end
    if (word_tick) begin
      for (int k = 0; k < 2; k++) begin
        vcp_nxt[k] = vc;
        vc = vc - vcp_r[k];
      end
      for (int k = 0; k < 4; k++) begin
        icp_nxt[k] = ic;
        ic = ic - icp_r[k];
      end
      hv_nxt[2] = hv_r[1];
      hv_nxt[1] = hv_r[0];
      hv_nxt[0] = 32'(vc) <<< pmd_pkg::SINC2_SH;
      hi_nxt[2] = hi_r[1];
      hi_nxt[1] = hi_r[0];
      hi_nxt[0] = 32'(ic) >>> pmd_pkg::SINC4_SH;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      kcnt_r <= 8'h00;
      sub8_r <= 3'h0;
      dec_r <= 7'h00;
      vsy_r <= 2'h0;
      isy_r <= 2'h0;
      vsh_r <= '0;
      vin_r <= '{default: '0};
      vcp_r <= '{default: '0};
      iin_r <= '{default: '0};
      icp_r <= '{default: '0};
      hv_r <= '{default: '0};
      hi_r <= '{default: '0};
      s1_r <= 1'b0;
    end else begin
      kcnt_r <= kcnt_nxt;
      sub8_r <= sub8_nxt;
      dec_r <= dec_nxt;
      vsy_r <= vsy_nxt;
      isy_r <= isy_nxt;
      vsh_r <= vsh_nxt;
      vin_r <= vin_nxt;
      vcp_r <= vcp_nxt;
      iin_r <= iin_nxt;
      icp_r <= icp_nxt;
      hv_r <= hv_nxt;
      hi_r <= hi_nxt;
      s1_r <= word_tick;
    end
  end

  // ==========================================================
  // per-conversion datapath
  logic signed [31:0] lpv_r, lpv_nxt, lpi_r, lpi_nxt; // dc trackers
  logic [23:0]        instv_r, instv_nxt, insti_r, insti_nxt;
  logic [23:0]        instp_r, instp_nxt;
  logic signed [47:0] eacc_r, eacc_nxt;
  logic [47:0]        sqv_r, sqv_nxt, sqi_r, sqi_nxt;
  logic [23:0]        ncnt_r, ncnt_nxt;
  logic signed [39:0] pacc_r, pacc_nxt;
  logic               ppos_nxt, pneg_nxt, cyc_end;
  logic signed [31:0] fv, fi, vsel, isel, iap;
  logic signed [63:0] cv, ci, pw, efin, pa;
  logic [47:0]        sqv_f, sqi_f;

  // filter, correct, multiply and accumulate once per word
  always_comb begin
    fv = fir3(hv_r[2], hv_r[1], hv_r[0]);
    fi = fir3(hi_r[2], hi_r[1], hi_r[0]);
    iap = fi - 2 * lpi_r;
    // allpass 1-2*lowpass has the blocker's phase, unit gain
    if (cfg.v_hpf) vsel = fv - lpv_r;
    else if (cfg.i_hpf) vsel = fv - 2 * lpv_r;
    else vsel = fv;
    if (cfg.i_hpf) isel = fi - lpi_r;
    else if (cfg.v_hpf) isel = iap;
    else isel = fi;
    if (cfg.i_rng) isel = isel * pmd_pkg::RNG_MUL;
    cv = 64'(signed'(sat24(64'(vsel) + 64'(signed'(voff_r)))));
    // gain is unsigned: widen it as a positive signed word so that the
    // product and the shift keep the sign of a negative sample
    cv = (cv * 64'(signed'({1'b0, vgn_r}))) >>> pmd_pkg::GAIN_SH;
    cv = 64'(signed'(sat24(cv)));
    ci = 64'(signed'(sat24(64'(isel) + 64'(signed'(ioff_r)))));
    ci = (ci * 64'(signed'({1'b0, ign_r}))) >>> pmd_pkg::GAIN_SH;
    ci = 64'(signed'(sat24(ci)));
    pw = 64'(signed'(sat24((cv * ci) >>> pmd_pkg::FRAC_SH)));
    efin = 64'(eacc_r) + pw;
    sqv_f = sqv_r + 48'((cv * cv) >>> pmd_pkg::FRAC_SH);
    sqi_f = sqi_r + 48'((ci * ci) >>> pmd_pkg::FRAC_SH);
    cyc_end = s1_r && (ncnt_r + 24'h00_0001 >= ncyc_r);
    lpv_nxt = lpv_r;
    lpi_nxt = lpi_r;
    instv_nxt = instv_r;
    insti_nxt = insti_r;
    instp_nxt = instp_r;
    eacc_nxt = eacc_r;
    sqv_nxt = sqv_r;
    sqi_nxt = sqi_r;
    ncnt_nxt = ncnt_r;
    pa = 64'(pacc_r);
    ppos_nxt = 1'b0;
    pneg_nxt = 1'b0;
    if (s1_r) begin
      lpv_nxt = lpv_r + ((fv - lpv_r) >>> pmd_pkg::HPF_SH);
      lpi_nxt = lpi_r + ((fi - lpi_r) >>> pmd_pkg::HPF_SH);
      instv_nxt = cv[23:0];
      insti_nxt = ci[23:0];
      instp_nxt = pw[23:0];
      pa = pa + pw;
      // one pulse per quantum; a large backlog drains over words
      if (pa >= 64'(PULSE_Q)) begin
        ppos_nxt = 1'b1;
        pa = pa - 64'(PULSE_Q);
      end else if (pa <= -64'(PULSE_Q)) begin
        pneg_nxt = 1'b1;
        pa = pa + 64'(PULSE_Q);
      end
      eacc_nxt = cyc_end ? 48'sd0 : efin[47:0];
      sqv_nxt = cyc_end ? 48'h0000_0000_0000 : sqv_f;
      sqi_nxt = cyc_end ? 48'h0000_0000_0000 : sqi_f;
      ncnt_nxt = cyc_end ? 24'h00_0000 : ncnt_r + 24'h00_0001;
    end
    pacc_nxt = pa[39:0];
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lpv_r <= '0;
      lpi_r <= '0;
      instv_r <= 24'h00_0000;
      insti_r <= 24'h00_0000;
      instp_r <= 24'h00_0000;
      eacc_r <= '0;
      sqv_r <= '0;
      sqi_r <= '0;
      ncnt_r <= 24'h00_0000;
      pacc_r <= '0;
      pulse_pos <= 1'b0;
      pulse_neg <= 1'b0;
    end else begin
      lpv_r <= lpv_nxt;
      lpi_r <= lpi_nxt;
      instv_r <= instv_nxt;
      insti_r <= insti_nxt;
      instp_r <= instp_nxt;
      eacc_r <= eacc_nxt;
      sqv_r <= sqv_nxt;
      sqi_r <= sqi_nxt;
      ncnt_r <= ncnt_nxt;
      pacc_r <= pacc_nxt;
      pulse_pos <= ppos_nxt;
      pulse_neg <= pneg_nxt;
    end
  end

  // ==========================================================
  // end-of-cycle mean and root; a cycle ending while busy is dropped
  pmd_pkg::rms_st_t st_r, st_nxt;
  logic [4:0]        bit_r, bit_nxt;
  logic [23:0]       qv_r, qv_nxt, qi_r, qi_nxt, dn_r, dn_nxt;
  logic [47:0]       tv_r, tv_nxt, ti_r, ti_nxt;
  logic [23:0]       enh_r, enh_nxt;
  pmd_pkg::result_t  res_r, res_nxt;

  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    qv_nxt = qv_r;
    qi_nxt = qi_r;
    dn_nxt = dn_r;
    tv_nxt = tv_r;
    ti_nxt = ti_r;
    enh_nxt = enh_r;
    res_nxt = res_r;
    case (st_r)
      pmd_pkg::ST_IDLE: begin
        if (cyc_end) begin
          st_nxt = pmd_pkg::ST_DIV;
          bit_nxt = 5'd23;
          qv_nxt = 24'h00_0000;
          qi_nxt = 24'h00_0000;
          dn_nxt = (ncyc_r == 24'h00_0000) ? 24'h00_0001 : ncyc_r;
          tv_nxt = sqv_f;
          ti_nxt = sqi_f;
          enh_nxt = sat24(efin >>> pmd_pkg::ENERGY_SH);
        end
      end
      pmd_pkg::ST_DIV: begin
        qv_nxt = try_bit(qv_r, bit_r, dn_r, tv_r, 1'b0);
        qi_nxt = try_bit(qi_r, bit_r, dn_r, ti_r, 1'b0);
        bit_nxt = bit_r - 5'd1;
        if (bit_r == 5'd0) begin
          st_nxt = pmd_pkg::ST_ROOT;
          bit_nxt = 5'd23;
          tv_nxt = {qv_nxt, 24'h00_0000} >> 1;
          ti_nxt = {qi_nxt, 24'h00_0000} >> 1;
          qv_nxt = 24'h00_0000;
          qi_nxt = 24'h00_0000;
        end
      end
      pmd_pkg::ST_ROOT: begin
        qv_nxt = try_bit(qv_r, bit_r, dn_r, tv_r, 1'b1);
        qi_nxt = try_bit(qi_r, bit_r, dn_r, ti_r, 1'b1);
        bit_nxt = bit_r - 5'd1;
        if (bit_r == 5'd0) st_nxt = pmd_pkg::ST_FIN;
      end
      pmd_pkg::ST_FIN: begin
        res_nxt = '{energy: enh_r, vrms: qv_r, irms: qi_r};
        st_nxt = pmd_pkg::ST_IDLE;
      end
      default: st_nxt = pmd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= pmd_pkg::ST_IDLE;
      bit_r <= 5'd0;
      qv_r <= 24'h00_0000;
      qi_r <= 24'h00_0000;
      dn_r <= 24'h00_0001;
      tv_r <= '0;
      ti_r <= '0;
      enh_r <= 24'h00_0000;
      res_r <= '0;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      qv_r <= qv_nxt;
      qi_r <= qi_nxt;
      dn_r <= dn_nxt;
      tv_r <= tv_nxt;
      ti_r <= ti_nxt;
      enh_r <= enh_nxt;
      res_r <= res_nxt;
    end
  end

  // ==========================================================
  // wishbone slave, one wait state, unmapped reads give zero
  logic       req;
  logic [5:0] widx;
  logic [31:0] be;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign widx = wb_adr_i[7:2];
  assign be = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign irq = |(stat_r & mask_r);

  always_comb begin
    logic [31:0] w;
    w = wb_dat_i & be;
    cfg_nxt = cfg_r;
    voff_nxt = voff_r;
    ioff_nxt = ioff_r;
    vgn_nxt = vgn_r;
    ign_nxt = ign_r;
    ncyc_nxt = ncyc_r;
    mask_nxt = mask_r;
    // hardware set wins over a same-cycle clear
    stat_nxt = stat_r;
    if (req && wb_we_i && widx == pmd_pkg::R_STAT) stat_nxt &= ~w[1:0];
    stat_nxt[pmd_pkg::ST_CONVERSION_READY_FLAG] |= s1_r;
    stat_nxt[pmd_pkg::ST_CYCLE_DONE_FLAG] |= st_r == pmd_pkg::ST_FIN;
    ack_nxt = req;
    dat_nxt = 32'h0000_0000;
    if (req && wb_we_i) begin
      case (widx)
        pmd_pkg::R_CFG:   cfg_nxt = (cfg_r & ~be[10:0]) | w[10:0];
        pmd_pkg::R_VOFF:  voff_nxt = (voff_r & ~be[23:0]) | w[23:0];
        pmd_pkg::R_IOFF:  ioff_nxt = (ioff_r & ~be[23:0]) | w[23:0];
        pmd_pkg::R_VGAIN: vgn_nxt = (vgn_r & ~be[23:0]) | w[23:0];
        pmd_pkg::R_IGAIN: ign_nxt = (ign_r & ~be[23:0]) | w[23:0];
        pmd_pkg::R_NCYC:  ncyc_nxt = (ncyc_r & ~be[23:0]) | w[23:0];
        pmd_pkg::R_MASK:  mask_nxt = (mask_r & ~be[1:0]) | w[1:0];
        default: ;
      endcase
    end else if (req) begin
      case (widx)
        pmd_pkg::R_CFG:   dat_nxt = 32'(cfg_r);
        pmd_pkg::R_VOFF:  dat_nxt = 32'(voff_r);
        pmd_pkg::R_IOFF:  dat_nxt = 32'(ioff_r);
        pmd_pkg::R_VGAIN: dat_nxt = 32'(vgn_r);
        pmd_pkg::R_IGAIN: dat_nxt = 32'(ign_r);
        pmd_pkg::R_NCYC:  dat_nxt = 32'(ncyc_r);
        pmd_pkg::R_STAT:  dat_nxt = 32'(stat_r);
        pmd_pkg::R_MASK:  dat_nxt = 32'(mask_r);
        pmd_pkg::R_INSTV: dat_nxt = 32'(instv_r);
        pmd_pkg::R_INSTI: dat_nxt = 32'(insti_r);
        pmd_pkg::R_INSTP: dat_nxt = 32'(instp_r);
        pmd_pkg::R_ENRG:  dat_nxt = 32'(res_r.energy);
        pmd_pkg::R_VRMS:  dat_nxt = 32'(res_r.vrms);
        pmd_pkg::R_IRMS:  dat_nxt = 32'(res_r.irms);
        default:          dat_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= pmd_pkg::CFG_RST;
      voff_r <= pmd_pkg::OFF_RST;
      ioff_r <= pmd_pkg::OFF_RST;
      vgn_r <= pmd_pkg::GAIN_RST;
      ign_r <= pmd_pkg::GAIN_RST;
      ncyc_r <= pmd_pkg::NCYC_RST;
      stat_r <= pmd_pkg::FLG_RST;
      mask_r <= pmd_pkg::FLG_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      cfg_r <= cfg_nxt;
      voff_r <= voff_nxt;
      ioff_r <= ioff_nxt;
      vgn_r <= vgn_nxt;
      ign_r <= ign_nxt;
      ncyc_r <= ncyc_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      wb_ack_o <= ack_nxt;
      wb_dat_o <= dat_nxt;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [19:0] dcnt_h;   // divided clocks since last word
  logic        seen_h;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dcnt_h <= '0;
      seen_h <= 1'b0;
    end else begin
      dcnt_h <= word_tick ? 20'h0_0000 : dcnt_h + 20'(dtick);
      seen_h <= seen_h | word_tick;
    end
  end
  a_mod_space: assert property (mod_tick |=> !mod_tick [*7])
    else $error("modulator sample spacing short");
  a_word_rate: assert property (word_tick && seen_h |->
    dcnt_h == 20'(pmd_pkg::WORD_DCLK - 1)) else $error("word rate off");
  a_conv_flag: assert property (s1_r |=> stat_r[0])
    else $error("conversion flag not set");
  a_cycle_flag: assert property (st_r == pmd_pkg::ST_FIN |=>
    stat_r[1] && (irq == (mask_r[1] | (mask_r[0] & stat_r[0]))))
    else $error("cycle flag not set");
  a_power_reg: assert property (
    s1_r |=> instp_r == $past(pw[23:0]))
    else $error("power register stale");
  a_root_time: assert property ($rose(st_r == pmd_pkg::ST_DIV) |->
    ##24 st_r == pmd_pkg::ST_ROOT ##24 st_r == pmd_pkg::ST_FIN)
    else $error("rms engine timing wrong");
  a_res_joint: assert property ($changed(res_r) |->
    $past(st_r) == pmd_pkg::ST_FIN) else $error("results split");
  a_apf_sel: assert property (
    cfg.v_hpf && !cfg.i_hpf && !cfg.i_rng |-> isel == iap)
    else $error("allpass not inserted");
  a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  c_cycle: cover property (st_r == pmd_pkg::ST_FIN);
  c_pulse: cover property (pulse_pos);
  c_apf: cover property (s1_r && cfg.v_hpf && !cfg.i_hpf);
endmodule : power_measurement_datapath

// File: pmd_pkg.sv
// constants and carrier types for the power measurement datapath
package pmd_pkg;
  // ==========================================================
  // timing, counted in divided master clocks; WORD_MOD counts modulator samples
  localparam int MOD_DCLK  = 8;    // divided clocks per modulator sample
  localparam int WORD_DCLK = 1024; // divided clocks per output word
  localparam int WORD_MOD  = WORD_DCLK / MOD_DCLK;
  // ==========================================================
  // arithmetic scaling
  localparam int ENERGY_SH = 12;   // energy sum shift
  localparam int FRAC_SH   = 23;   // fractional point of 24-bit words
  localparam int GAIN_SH   = 22;   // gain word holds 1.0 at bit 22
  localparam int FIR_SH    = 4;    // droop correction strength
  localparam int HPF_SH    = 14;   // dc tracking pole
  localparam int SINC2_SH  = 9;    // sinc2 word up to 24 bits
  localparam int SINC4_SH  = 5;    // sinc4 word down to 24 bits
  localparam int RNG_MUL   = 5;    // high-gain current range factor
  // ==========================================================
  // register word indices, byte address is four times these
  localparam logic [5:0] R_CFG   = 6'h00;
  localparam logic [5:0] R_VOFF  = 6'h01;
  localparam logic [5:0] R_IOFF  = 6'h02;
  localparam logic [5:0] R_VGAIN = 6'h03;
  localparam logic [5:0] R_IGAIN = 6'h04;
  localparam logic [5:0] R_NCYC  = 6'h05;
  localparam logic [5:0] R_STAT  = 6'h06;
  localparam logic [5:0] R_MASK  = 6'h07;
  localparam logic [5:0] R_INSTV = 6'h08;
  localparam logic [5:0] R_INSTI = 6'h09;
  localparam logic [5:0] R_INSTP = 6'h0A;
  localparam logic [5:0] R_ENRG  = 6'h0B;
  localparam logic [5:0] R_VRMS  = 6'h0C;
  localparam logic [5:0] R_IRMS  = 6'h0D;
  // ==========================================================
  // fields and reset values
  localparam int ST_CONVERSION_READY_FLAG = 0;      // conversion_ready_flag
  localparam int ST_CYCLE_DONE_FLAG = 1;      // cycle_done_flag
  localparam logic [10:0] CFG_RST  = 11'h000;
  localparam logic [23:0] OFF_RST  = 24'h00_0000;
  localparam logic [23:0] GAIN_RST = 24'h40_0000;
  localparam logic [23:0] NCYC_RST = 24'h00_0FA0;
  localparam logic [1:0]  FLG_RST  = 2'h0;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic       i_rng;   // current channel high-gain range
    logic       i_hpf;   // dc_block_stage on current
    logic       v_hpf;   // dc_block_stage on voltage
    logic       pad;
    logic [6:0] phase;   // phase_delay_code
  } cfg_t;
  typedef struct packed {
    logic [23:0] energy;
    logic [23:0] vrms;
    logic [23:0] irms;
  } result_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DIV  = 4'b0010,
    ST_ROOT = 4'b0100,
    ST_FIN  = 4'b1000
  } rms_st_t;
endpackage : pmd_pkg

// File: mod_source.sv
`timescale 1ns/10ps
// partner model: modulator bitstreams from repeating bit patterns
module mod_source (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [15:0] v_pat,
  input  wire logic [15:0] i_pat,
  output logic             v_mod_bit,
  output logic             i_mod_bit
);
  // ============================================================
  // pacing: one bit per eight clocks; period 16 divides a word,
  // so every word sees whole patterns and the mean is exact
  logic [2:0] tick_r; // divided clock phase
  logic [3:0] pos_r;  // bit position inside the pattern
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_r <= 3'h0;
      pos_r  <= 4'h0;
    end else begin
      tick_r <= tick_r + 3'h1;
      if (tick_r == 3'h7) pos_r <= pos_r + 4'h1;
    end
  end
  assign v_mod_bit = v_pat[pos_r];
  assign i_mod_bit = i_pat[pos_r];
endmodule : mod_source

// File: testbench.sv
`timescale 1ns/10ps
// self-checking bench for the power measurement datapath
module testbench;
  // ============================================================
  // stimulus, observation and model state
  logic        core_clk, nrst, cyc, stb, we, irq, ack, pp, pn;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rd, wdo;
  logic [15:0] vpat, ipat;
  logic        vbit, ibit;
  int mismatches, compares, npos, nneg;
  int lv, li, voff, vg, ioff, ig, rng, ncyc;
  power_measurement_datapath #(.PULSE_Q(1 << 10)) dut_u (
    .core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_dat_o(wdo), .wb_ack_o(ack), .v_mod_bit(vbit), .i_mod_bit(ibit),
    .irq(irq), .pulse_pos(pp), .pulse_neg(pn));
  mod_source src_u (.core_clk(core_clk), .nrst(nrst), .v_pat(vpat),
    .i_pat(ipat), .v_mod_bit(vbit), .i_mod_bit(ibit));
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    npos += (pp === 1'b1);
    nneg += (pn === 1'b1);
  end
  // ============================================================
  // helpers: saturation, compare, closing report
  function automatic int sat(longint x);
    return x > 8388607 ? 8388607 : (x < -8388608 ? -8388608 : int'(x));
  endfunction : sat
  task automatic chk(input string m, input logic [31:0] g, input int e,
                     input int tol);
    int d;
    d = int'($signed(g[23:0])) - e;
    compares++;
    if (!(g[31:24] === 8'h00 && ^g !== 1'bx && d <= tol && d >= -tol)) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic hang(input string m);
    mismatches++;
    $display("ERROR %0t %s timeout", $time, m);
    conclude();
  endtask : hang
  // ============================================================
  // classic single cycle; waits for ack under a bound
  task automatic bus(input logic w, input logic [5:0] ix, input int d);
    int n;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {ix, 2'b00};
    dat <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) hang("bus");
    rd = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  // masked flag must not reach irq; then wait for the unmasked one
  task automatic waitf(input logic [1:0] m);
    int n;
    bus(1'b1, pmd_pkg::R_MASK, 0);
    chk("irq masked", 32'(irq), 0, 0);
    bus(1'b1, pmd_pkg::R_STAT, 3);
    bus(1'b1, pmd_pkg::R_MASK, 32'(m));
    for (n = 0; irq !== 1'b1 && n < 12000; n++) @(posedge core_clk);
    if (n >= 12000) hang("flag");
    bus(1'b0, pmd_pkg::R_STAT, 0);
    chk("flag", rd & 32'(m), 32'(m), 0);
  endtask : waitf
  // ============================================================
  // one steady measurement against the integer model
  task automatic measure(input string nm);
    int ev, ei, ep;
    ev = sat((longint'(lv + voff) * vg) >>> 22);
    ei = sat((longint'(li * rng + ioff) * ig) >>> 22);
    ep = sat((longint'(ev) * ei) >>> 23);
    // fresh start: clears filters and the pulse backlog of the last
    // test, whose sign would otherwise leak into this one
    nrst <= 1'b0;
    @(posedge core_clk);
    nrst <= 1'b1;
    bus(1'b1, pmd_pkg::R_CFG, {rng == 5, 3'h0, 7'($urandom)});
    bus(1'b1, pmd_pkg::R_VOFF, voff & 32'h00FF_FFFF);
    bus(1'b1, pmd_pkg::R_IOFF, ioff & 32'h00FF_FFFF);
    bus(1'b1, pmd_pkg::R_VGAIN, vg);
    bus(1'b1, pmd_pkg::R_IGAIN, ig);
    bus(1'b1, pmd_pkg::R_NCYC, ncyc);
    repeat (7) waitf(2'b01);
    npos = 0;
    nneg = 0;
    bus(1'b0, pmd_pkg::R_INSTV, 0);
    chk("inst v", rd, ev, 2);
    bus(1'b0, pmd_pkg::R_INSTI, 0);
    chk("inst i", rd, ei, 2);
    bus(1'b0, pmd_pkg::R_INSTP, 0);
    chk("power", rd, ep, 4);
    repeat (2) waitf(2'b10);
    bus(1'b0, pmd_pkg::R_ENRG, 0);
    chk("energy", rd, sat((longint'(ep) * ncyc) >>> 12), 2);
    bus(1'b0, pmd_pkg::R_VRMS, 0);
    chk("vrms", rd, ev < 0 ? sat(-ev) : ev, 8);
    bus(1'b0, pmd_pkg::R_IRMS, 0);
    chk("irms", rd, ei < 0 ? sat(-ei) : ei, 8);
    chk("wrong pulses", ep > 0 ? nneg : npos, 0, 0);
    chk("no pulses", 32'((ep > 0 ? npos : nneg) > 0), 1, 0);
    $display("test %s done", nm);
  endtask : measure
  // ============================================================
  // main sequence
  logic [5:0] ri [6] = '{pmd_pkg::R_CFG, pmd_pkg::R_VGAIN,
    pmd_pkg::R_IGAIN, pmd_pkg::R_NCYC, pmd_pkg::R_ENRG, 6'h3F};
  int         rv [6] = '{0, 32'h0040_0000, 32'h0040_0000, 32'h0000_0FA0,
    0, 0};
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    {cyc, stb, we, adr, dat} = '0;
    sel = 4'hF;
    vpat = 16'h3FFF;
    ipat = 16'h0FFF;
    void'($urandom(70934));
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (ri[k]) begin
      bus(1'b0, ri[k], 0);
      chk("reset value", rd, rv[k], 0);
    end
    bus(1'b1, pmd_pkg::R_ENRG, $urandom);
    bus(1'b0, pmd_pkg::R_ENRG, 0);
    chk("read only", rd, 0, 0);
    sel <= 4'h3;
    bus(1'b1, pmd_pkg::R_VOFF, 32'h0012_3456);
    sel <= 4'hF;
    bus(1'b0, pmd_pkg::R_VOFF, 0);
    chk("byte lanes", rd, 32'h0000_3456, 0);
    $display("test registers done");
    {lv, li, rng, voff, ioff, ncyc} = {32'sd6291456, 32'sd4194304, 32'sd1,
      32'sd0, 32'sd0, 32'sd4};
    vg = 32'h0040_0000;
    ig = vg;
    measure("basic");
    ipat <= 16'h01FF;
    {li, rng, ncyc} = {32'sd1048576, 32'sd5, 32'sd6};
    vg = $urandom_range(32'h0040_0000, 32'h0010_0000);
    ig = $urandom_range(32'h0040_0000, 32'h0010_0000);
    voff = int'($urandom_range(0, 32'h0003_FFFF)) - 131072;
    ioff = int'($urandom_range(0, 32'h0000_FFFF)) - 32768;
    measure("gain range");
    vpat <= 16'h0001;
    ipat <= 16'h0FFF;
    {lv, li, rng, voff, ioff, ncyc} = {-32'sd7340032, 32'sd4194304,
      32'sd1, 32'sd0, 32'sd0, 32'sd8};
    measure("negative");
    // dc block on one channel, allpass on the other; the trackers start
    // from reset, so their pull stays well inside the tolerance
    for (int h = 1; h < 3; h++) begin
      nrst <= 1'b0;
      @(posedge core_clk);
      nrst <= 1'b1;
      bus(1'b1, pmd_pkg::R_CFG, h << 8);
      repeat (7) waitf(2'b01);
      bus(1'b0, pmd_pkg::R_INSTV, 0);
      chk("blocked v", rd, lv, 16384);
      bus(1'b0, pmd_pkg::R_INSTI, 0);
      chk("blocked i", rd, li, 16384);
    end
    $display("test dc block done");
    conclude();
  end
endmodule : testbench
